//--- inc/aux_adc_pkg.sv
// constants shared by the auxiliary converter control block
// assumes a 16-bit indexed register port driven by the codec link logic
// Notes on behaviour
// R1: power-on bit keeps converter powered, else down
// R2: start bit begins conversion, then self-clears
// R3: sync mode: start arms, sync rise starts
// R4: direct mode: start write begins, sync ignored
// R5: select field routes plates and auxiliary inputs
// R6: bypass bit connects reference to bypass pin
// R7: software writes zero to test input bit
// R8: valid flag reads zero during conversion
// R9: completion stores result, sets valid flag
// R10: control at index 0x66, resets zero
// R11: result at 0x68, zero reset, read-only
// R12: ready status latched, cleared by writing one
// R13: sync edge ignored unless enabled and armed
// R14: software powers up, waits for valid flag
package aux_adc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [6:0]  CTRL_INDEX      = 7'h66;   // control register index
  localparam logic [6:0]  RESULT_INDEX    = 7'h68;   // result register index
  localparam logic [6:0]  IRQ_INDEX       = 7'h62;   // interrupt status index
  localparam logic [15:0] REG_RESET       = 16'h0000; // reset value of all regs
  // ****************************************
  // field positions
  // ****************************************
  localparam int POWER_BIT  = 15; // converter power-on
  localparam int START_BIT  = 7;  // conversion start
  localparam int TEST_BIT   = 5;  // test extended input enable
  localparam int SEL_HI     = 4;  // input select high bit
  localparam int SEL_LO     = 2;  // input select low bit
  localparam int BYPASS_BIT = 1;  // reference bypass connect
  localparam int SYNC_BIT   = 0;  // sync start enable
  localparam int VALID_BIT  = 15; // result valid flag
  localparam int READY_BIT  = 11; // ready interrupt status
  localparam int RESULT_W   = 10; // result width
  // writable bits of the control register (start bit self-clears)
  localparam logic [15:0] CTRL_KEEP_MASK  = 16'h803F;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 4;    // 250 MHz
  localparam int CONV_TIME_NS    = 400;  // conversion time, plain default
  localparam int CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONVERT} conv_state_t;
endpackage

//--- src/aux_adc_control.sv
// control, sequencing and result logic for the auxiliary converter
// assumes link logic presents one-cycle register writes and combinational reads
`timescale 1ns/100ps
module aux_adc_control import aux_adc_pkg::*; #(
  parameter int CONV_CYC = CONV_CYCLES  // conversion length in clocks
) (
  input  wire logic          clock_in,              // 250 MHz clock
  input  wire logic          resetn_in,             // async reset, active low
  input  wire logic [6:0]    reg_index_in,          // register index
  input  wire logic          reg_write_in,          // one-cycle write strobe
  input  wire logic [15:0]   reg_wdata_in,          // write data
  output logic      [15:0]   reg_rdata_out,         // read data for index
  input  wire logic          external_sync_in,      // sync start pin
  input  wire logic [9:0]    adc_data_in,           // comparator result bits
  output logic               converter_power_on_out, // converter powered
  output logic               adc_sample_out,        // conversion under way
  output logic [7:0]         input_route_out,       // one-hot analog mux
  output logic               reference_bypass_out,  // reference to bypass pin
  output logic               converter_ready_irq_status_out // ready status
);
  // ****************************************
  // state
  // ****************************************
  logic [15:0] control;           // control register
  logic [15:0] next_control;      // its next value
  logic        ready_status;      // sticky ready status
  logic        next_ready_status; // its next value
  logic        valid;             // result valid flag
  logic        next_valid;        // its next value
  conv_state_t state;             // sequencer state
  conv_state_t next_state;        // its next value
  logic [15:0] count;             // conversion counter
  logic [15:0] next_count;        // its next value
  logic        sync_prev;         // last sync level, for edge detect
  logic        done;              // last conversion cycle
  logic [9:0]  result;            // stored result
  logic        wr_ctrl;           // write to control
  logic        wr_irq;            // write to interrupt status
  logic        start_req;         // start bit written as one
  logic        sync_rise;         // rising edge on sync pin

  // decode index match, used for several registers
  function automatic logic hit(input logic [6:0] idx, input logic [6:0] want);
    hit = (idx == want);
  endfunction

  assign wr_ctrl   = reg_write_in && hit(reg_index_in, CTRL_INDEX);
  assign wr_irq    = reg_write_in && hit(reg_index_in, IRQ_INDEX);
  assign start_req = wr_ctrl && reg_wdata_in[START_BIT];
  assign sync_rise = external_sync_in && !sync_prev;
  assign done      = (state == ST_CONVERT) && (count == 16'(CONV_CYC - 1));

  // ****************************************
  // control register
  // ****************************************
  // start bit never stored, so it reads back as zero
  always_comb begin
    next_control = control;
    if (wr_ctrl) begin
      next_control = reg_wdata_in & CTRL_KEEP_MASK; // R2 R10 R7
    end
  end

  // register the control word
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      control <= REG_RESET; // R10
    end else begin
      control <= next_control;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // idle -> armed (sync mode) or convert (direct); powered down aborts
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      ST_IDLE: begin
        if (start_req && control[POWER_BIT]) begin
          if (next_control[SYNC_BIT]) begin
            next_state = ST_ARMED; // R3
          end else begin
            next_state = ST_CONVERT; // R2 R4
            next_count = '0;
          end
        end
      end
      ST_ARMED: begin
        // edge only counts while armed and sync mode still on
        if (!control[SYNC_BIT]) begin
          next_state = ST_IDLE; // R13
        end else if (sync_rise) begin
          next_state = ST_CONVERT; // R3 R13
          next_count = '0;
        end
      end
      ST_CONVERT: begin
        next_count = count + 16'd1;
        if (done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (!control[POWER_BIT]) begin
      next_state = ST_IDLE; // R1
    end
  end

  // register state, count and sync history; sync history resets to the idle pin level
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state     <= ST_IDLE;
      count     <= '0;
      sync_prev <= 1'b0;
    end else begin
      state     <= next_state;
      count     <= next_count;
      sync_prev <= external_sync_in;
    end
  end

  // ****************************************
  // valid flag and ready status
  // ****************************************
  // set wins over a clear written in the same cycle
  always_comb begin
    next_valid = valid;
    if (next_state == ST_CONVERT) begin
      next_valid = 1'b0; // R8
    end else if (done) begin
      next_valid = 1'b1; // R9
    end
    next_ready_status = ready_status;
    if (wr_irq && reg_wdata_in[READY_BIT]) begin
      next_ready_status = 1'b0; // R12
    end
    if (done) begin
      next_ready_status = 1'b1; // R12
    end
  end

  // register the two flags
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      valid        <= 1'b0;
      ready_status <= 1'b0;
    end else begin
      valid        <= next_valid;
      ready_status <= next_ready_status;
    end
  end

  // result holder, written at the end of each conversion
  result_store #(.WIDTH(RESULT_W)) u_store (
    .clock_in (clock_in),
    .resetn_in(resetn_in),
    .store_in (done),
    .data_in  (adc_data_in),
    .data_out (result)
  );

  // ****************************************
  // read mux
  // ****************************************
  // unmapped indexes read zero; result reserved bits read zero
  always_comb begin
    reg_rdata_out = REG_RESET;
    if (hit(reg_index_in, CTRL_INDEX)) begin
      reg_rdata_out = control;
    end else if (hit(reg_index_in, RESULT_INDEX)) begin
      reg_rdata_out = REG_RESET; // R11
      reg_rdata_out[VALID_BIT] = valid;
      reg_rdata_out[RESULT_W-1:0] = result;
    end else if (hit(reg_index_in, IRQ_INDEX)) begin
      reg_rdata_out[READY_BIT] = ready_status;
    end
  end

  // ****************************************
  // analog controls
  // ****************************************
  assign converter_power_on_out = control[POWER_BIT];  // R1
  assign reference_bypass_out   = control[BYPASS_BIT]; // R6
  assign adc_sample_out         = (state == ST_CONVERT);
  assign converter_ready_irq_status_out = ready_status;

  // one-hot input route
  generate
    for (genvar i = 0; i < 8; i++) begin : g_route
      assign input_route_out[i] = control[POWER_BIT] && (control[SEL_HI:SEL_LO] == 3'(i)); // R5
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  property p_start_self_clears;
    @(posedge clock_in) disable iff (!resetn_in)
      wr_ctrl |=> !control[START_BIT];
  endproperty
  a_start_self_clears: assert property (p_start_self_clears) else $error("start bit stayed set"); // R2

  property p_direct_start;
    @(posedge clock_in) disable iff (!resetn_in)
      (state == ST_IDLE && start_req && control[POWER_BIT] && !reg_wdata_in[SYNC_BIT]) |=> adc_sample_out;
  endproperty
  a_direct_start: assert property (p_direct_start) else $error("direct start missed"); // R4

  property p_armed_waits;
    @(posedge clock_in) disable iff (!resetn_in)
      (state == ST_ARMED && !sync_rise) |=> !adc_sample_out;
  endproperty
  a_armed_waits: assert property (p_armed_waits) else $error("armed converter started early"); // R13

  property p_sync_start;
    @(posedge clock_in) disable iff (!resetn_in)
      (state == ST_ARMED && sync_rise && control[SYNC_BIT] && control[POWER_BIT]) |=> adc_sample_out;
  endproperty
  a_sync_start: assert property (p_sync_start) else $error("sync edge did not start"); // R3

  property p_valid_low;
    @(posedge clock_in) disable iff (!resetn_in)
      adc_sample_out |-> !valid;
  endproperty
  a_valid_low: assert property (p_valid_low) else $error("valid set during conversion"); // R8

  property p_done_sets;
    @(posedge clock_in) disable iff (!resetn_in)
      done |=> valid && ready_status && result == $past(adc_data_in);
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("completion not recorded"); // R9

  property p_power_off;
    @(posedge clock_in) disable iff (!resetn_in)
      !converter_power_on_out |=> !adc_sample_out;
  endproperty
  a_power_off: assert property (p_power_off) else $error("converting while powered down"); // R1

  property p_bypass;
    @(posedge clock_in) disable iff (!resetn_in)
      reference_bypass_out == control[BYPASS_BIT] && $onehot0(input_route_out);
  endproperty
  a_bypass: assert property (p_bypass) else $error("analog control mismatch"); // R6

  property p_ctrl_write;
    @(posedge clock_in) disable iff (!resetn_in)
      wr_ctrl |=> control == ($past(reg_wdata_in) & CTRL_KEEP_MASK);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored"); // R10

  property p_result_read;
    @(posedge clock_in) disable iff (!resetn_in)
      (reg_index_in == RESULT_INDEX) |-> (reg_rdata_out[VALID_BIT-1:RESULT_W] == '0) &&
        (reg_rdata_out[VALID_BIT] == valid) && (reg_rdata_out[RESULT_W-1:0] == result);
  endproperty
  a_result_read: assert property (p_result_read) else $error("result read mismatch"); // R11

  property p_result_ro;
    @(posedge clock_in) disable iff (!resetn_in)
      (reg_write_in && reg_index_in == RESULT_INDEX && !done) |=> result == $past(result);
  endproperty
  a_result_ro: assert property (p_result_ro) else $error("result changed by a write"); // R11

  property p_status_clear;
    @(posedge clock_in) disable iff (!resetn_in)
      (wr_irq && reg_wdata_in[READY_BIT] && !done) |=> !ready_status;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("ready status not cleared"); // R12

  property p_status_set_wins;
    @(posedge clock_in) disable iff (!resetn_in)
      (done && wr_irq && reg_wdata_in[READY_BIT]) |=> ready_status;
  endproperty
  a_status_set_wins: assert property (p_status_set_wins) else $error("clear beat completion"); // R12

  property p_status_sticky;
    @(posedge clock_in) disable iff (!resetn_in)
      (ready_status && !wr_irq) |=> ready_status;
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("ready status dropped"); // R12

  property p_disarm;
    @(posedge clock_in) disable iff (!resetn_in)
      (state == ST_ARMED && !control[SYNC_BIT]) |=> (state == ST_IDLE);
  endproperty
  a_disarm: assert property (p_disarm) else $error("armed state kept without sync mode"); // R13

  property p_idle_stays;
    @(posedge clock_in) disable iff (!resetn_in)
      (state == ST_IDLE && !start_req) |=> !adc_sample_out;
  endproperty
  a_idle_stays: assert property (p_idle_stays) else $error("conversion without start"); // R4

  property p_route_select;
    @(posedge clock_in) disable iff (!resetn_in)
      converter_power_on_out |-> (input_route_out == (8'h01 << control[SEL_HI:SEL_LO]));
  endproperty
  a_route_select: assert property (p_route_select) else $error("input route mismatch"); // R5

  property p_route_off;
    @(posedge clock_in) disable iff (!resetn_in)
      !converter_power_on_out |-> (input_route_out == '0);
  endproperty
  a_route_off: assert property (p_route_off) else $error("input routed while powered down"); // R5
endmodule

//--- src/result_store.sv
// holds the last conversion result
// assumes the sequencer pulses store_in once per finished conversion
`timescale 1ns/100ps
module result_store import aux_adc_pkg::*; #(
  parameter int WIDTH = RESULT_W
) (
  input  wire logic             clock_in,   // system clock
  input  wire logic             resetn_in,  // async reset, active low
  input  wire logic             store_in,   // capture pulse
  input  wire logic [WIDTH-1:0] data_in,    // converter data
  output logic      [WIDTH-1:0] data_out    // held result
);
  logic [WIDTH-1:0] next_data; // next held value

  // ****************************************
  // capture
  // ****************************************
  // take new data only on a store pulse
  always_comb begin
    next_data = store_in ? data_in : data_out; // R9
  end

  // register the value
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      data_out <= '0;
    end else begin
      data_out <= next_data;
    end
  end
endmodule

//--- testbench/analog_source_model.sv
// stand-in for the analog mux and comparator chain
// assumes route and sample come straight from the control block
`timescale 1ns/100ps
module analog_source_model (
  input  wire logic       clock_in,  // system clock
  input  wire logic       sample_in, // conversion under way
  input  wire logic [7:0] route_in,  // one-hot input select
  output logic      [9:0] data_out   // comparator data
);
  // ****************************************
  // data source
  // ****************************************
  logic [9:0] churn = 10'h155; // junk outside conversions
  // churn each cycle so stale data never passes for a result
  always @(posedge clock_in) begin
    churn <= ~churn + 10'h003;
  end
  // each routed input gives its own code, so a wrong route shows
  assign data_out = sample_in ? {route_in, 2'b01} : churn;
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the converter control block
// assumes the short conversion parameter and one 250 MHz clock
`timescale 1ns/100ps
module tb_top;
  import aux_adc_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  localparam int conv_len = 4;  // shortened conversion
  logic        clock_in;        // system clock
  logic        resetn_in;       // reset, active low
  logic [6:0]  index;           // register index
  logic        write;           // write strobe
  logic [15:0] wdata;           // write data
  logic [15:0] rdata;           // read data
  logic        sync;            // external sync pin
  logic [9:0]  adc_data;        // model data
  logic        power;           // converter powered
  logic        busy;            // conversion under way
  logic [7:0]  route;           // one-hot route
  logic        bypass;          // reference on bypass pin
  logic        status;          // ready status
  logic [9:0]  last;            // expected held result
  int          errors;          // mismatches
  int          checks_done;     // comparisons
  int          cycles;          // timeout counter
  // ****************************************
  // design and partner
  // ****************************************
  aux_adc_control #(.CONV_CYC(conv_len)) u_dut (
    .clock_in(clock_in), .resetn_in(resetn_in), .reg_index_in(index),
    .reg_write_in(write), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .external_sync_in(sync), .adc_data_in(adc_data),
    .converter_power_on_out(power), .adc_sample_out(busy),
    .input_route_out(route), .reference_bypass_out(bypass),
    .converter_ready_irq_status_out(status));
  analog_source_model u_model (
    .clock_in(clock_in), .sample_in(busy), .route_in(route), .data_out(adc_data));
  // ****************************************
  // clock and timeout
  // ****************************************
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  // a hang counts as a mismatch and ends the run
  always @(posedge clock_in) begin
    cycles++;
    if (cycles >= 5000) begin
      errors++;
      test_done();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle strobe, launched and dropped on falling edges
  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    @(negedge clock_in);
    index = idx;
    wdata = d;
    write = 1'b1;
    @(negedge clock_in);
    write = 1'b0;
  endtask
  // read data is combinational, so settle a moment then look
  task automatic rd(input logic [6:0] idx, input logic [15:0] exp, input string what);
    @(negedge clock_in);
    index = idx;
    #1;
    chk(what, exp, rdata);
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(negedge clock_in);
      n++;
    end
    chk("busy", {15'h0000, lvl}, {15'h0000, busy});
  endtask
  // two-cycle high pulse, then settle
  task automatic pulse();
    @(negedge clock_in);
    sync = 1'b1;
    repeat (2) @(negedge clock_in);
    sync = 1'b0;
    @(negedge clock_in);
  endtask
  // one direct conversion on input s, bypass on odd inputs
  task automatic conv(input int s);
    logic [15:0] ctl;
    ctl = 16'h8000 | 16'(s << 2) | (s[0] ? 16'h0002 : 16'h0000);
    wr(CTRL_INDEX, ctl);
    wr(CTRL_INDEX, ctl | 16'h0080);
    wait_busy(1'b1, 3);
    rd(RESULT_INDEX, {6'h00, last}, "valid low");
    rd(CTRL_INDEX, ctl, "start cleared");
    chk("route", 16'h0001 << s, {8'h00, route});
    chk("bypass", {15'h0000, s[0]}, {15'h0000, bypass});
    wait_busy(1'b0, conv_len + 4);
    last = {8'h01 << s, 2'b01};
    rd(RESULT_INDEX, {6'h20, last}, "result");
    chk("status", 16'h0001, {15'h0000, status});
    wr(IRQ_INDEX, 16'h0800);
    chk("status clr", 16'h0000, {15'h0000, status});
  endtask
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    index = 7'h00;
    write = 1'b0;
    wdata = 16'h0000;
    sync = 1'b0;
    last = 10'h000;
    resetn_in = 1'b0;
    // two rising edges in reset, then release on a falling edge
    repeat (2) @(posedge clock_in);
    @(negedge clock_in);
    resetn_in = 1'b1;
    rd(CTRL_INDEX, 16'h0000, "ctrl reset");
    rd(RESULT_INDEX, 16'h0000, "result reset");
    chk("outputs", 16'h0000, {power, busy, route, bypass, status, 4'h0});
    wr(RESULT_INDEX, 16'hffff);
    rd(RESULT_INDEX, 16'h0000, "result ro");
    rd(7'h10, 16'h0000, "unmapped");
    wr(CTRL_INDEX, 16'h0080);
    wait_busy(1'b0, 2);
    for (int s = 0; s < 8; s++) begin
      conv(s);
    end
    pulse();
    chk("sync ignored", 16'h0000, {15'h0000, busy});
    wr(CTRL_INDEX, 16'h8001);
    pulse();
    chk("unarmed sync", 16'h0000, {15'h0000, busy});
    wr(CTRL_INDEX, 16'h8081);
    repeat (3) @(negedge clock_in);
    chk("armed idle", 16'h0000, {15'h0000, busy});
    sync = 1'b1;
    wait_busy(1'b1, 3);
    sync = 1'b0;
    wait_busy(1'b0, conv_len + 4);
    rd(RESULT_INDEX, {6'h20, 8'h01, 2'b01}, "sync result");
    // arm, then leave sync mode: a later edge must find nothing armed
    wr(CTRL_INDEX, 16'h8081);
    wr(CTRL_INDEX, 16'h8000);
    wr(CTRL_INDEX, 16'h8001);
    pulse();
    chk("disarmed sync", 16'h0000, {15'h0000, busy});
    // power off in mid conversion aborts it before the count ends
    wr(CTRL_INDEX, 16'h8080);
    wr(CTRL_INDEX, 16'h0000);
    wait_busy(1'b0, 1);
    rd(RESULT_INDEX, {6'h00, 8'h01, 2'b01}, "abort valid");
    chk("power off", 16'h0000, {7'h00, power, route});
    test_done();
  end
endmodule
